// file: design/wdog_regs.svh
`ifndef WDOG_REGS_SVH
`define WDOG_REGS_SVH
// Service key bytes
`define WDOG_KEY_FIRST 8'h55
`define WDOG_KEY_SECOND 8'hAA
// Illegal opcode values
`define WDOG_ILLEGAL_OPCODE_FLAG_A 8'hAC
`define WDOG_ILLEGAL_OPCODE_FLAG_B 8'h8D
// Low-power tick: 1 kHz period in ns, bus clock 20 ns
`define WDOG_LPO_PERIOD_NS 1000000
`define WDOG_CLK_PERIOD_NS 20
`define WDOG_LPO_DIV (`WDOG_LPO_PERIOD_NS / `WDOG_CLK_PERIOD_NS)
// Default timeout in watchdog ticks
`define WDOG_TIMEOUT_DEF 32'h0004_0000
`endif

// file: design/wdog_pkg.sv
`default_nettype none
package wdog_pkg;
	typedef enum logic [1:0] {
		WDOG_RUN = 2'b00,
		WDOG_RESET = 2'b01
	} wdog_state_t;
	typedef enum logic [1:0] {
		WDOG_CAUSE_NONE = 2'h0,
		WDOG_CAUSE_TIMEOUT = 2'h1,
		WDOG_CAUSE_KEY = 2'h2
	} wdog_cause_t;
endpackage : wdog_pkg
`default_nettype wire

// file: design/wdog_tick_if.sv
`default_nettype none
interface wdog_tick_if;
	logic tick;
	logic clear;
	modport src (output tick, input clear);
	modport snk (input tick, output clear);
endinterface : wdog_tick_if
`default_nettype wire

// file: design/wdog_tick.sv
`include "wdog_regs.svh"
`default_nettype none
module wdog_tick
	import wdog_pkg::*;
#(
	parameter int unsigned LPO_DIV = `WDOG_LPO_DIV
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	wdog_tick_if.src tk
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} wdog_tick_st_t;
	wdog_tick_st_t st_reg;
	wdog_tick_st_t st_next;

	// Divider stands in for the 1 kHz oscillator
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (tk.clear) begin
			st_next.cnt = 32'h0000_0000;
		end else if (st_reg.cnt >= 32'(LPO_DIV - 1)) begin
			st_next.cnt = 32'h0000_0000;
			st_next.tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign tk.tick = st_reg.tick;
endmodule : wdog_tick
`default_nettype wire

// file: design/wdog_top.sv
`include "wdog_regs.svh"
`default_nettype none
module wdog_top
	import wdog_pkg::*;
#(
	parameter int unsigned TIMEOUT = `WDOG_TIMEOUT_DEF,
	parameter int unsigned LPO_DIV = `WDOG_LPO_DIV,
	parameter int unsigned RST_LEN = 4
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic enable_i,
	input wire logic window_mode_select_i,
	input wire logic watchdog_clock_select_i,
	input wire logic stop_i,
	input wire logic debug_i,
	input wire logic cause_wr_i,
	input wire logic [7:0] cause_wdata_i,
	input wire logic opcode_fetch_i,
	input wire logic [7:0] opcode_i,
	input wire logic illegal_addr_i,
	output logic sys_reset_o,
	output logic watchdog_cause_flag_o,
	output logic illegal_opcode_flag_o,
	output logic illegal_addr_flag_o,
	output logic key_armed_o,
	output logic [31:0] count_o
);
	typedef struct packed {
		wdog_state_t state;
		logic [31:0] cnt;
		logic [7:0] rst_cnt;
		logic armed;
		logic cop_flag;
		logic illegal_opcode_flag_flag;
		logic ilad_flag;
		logic rst;
	} wdog_st_t;
	wdog_st_t st_reg;
	wdog_st_t st_next;
	wdog_tick_if tk ();
	logic inc;
	logic halted;
	logic windowed;
	logic in_window;
	logic bad_key;
	logic early;
	logic serviced;
	logic timeout;
	logic illegal_opcode_flag;

	// Low-power tick source
	wdog_tick #(
		.LPO_DIV(LPO_DIV)
	) u_tick (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.tk(tk)
	);

	// Clock choice and low-power events
	assign halted = stop_i | debug_i;
	assign inc = watchdog_clock_select_i ? tk.tick : 1'b1;
	assign tk.clear = watchdog_clock_select_i & halted;
	assign windowed = window_mode_select_i & ~watchdog_clock_select_i;
	// Window opens at 75 percent of the timeout
	assign in_window = st_reg.cnt >= 32'((TIMEOUT / 4) * 3);
	assign bad_key = cause_wr_i & (cause_wdata_i != `WDOG_KEY_FIRST)
		& (cause_wdata_i != `WDOG_KEY_SECOND);
	assign early = windowed & cause_wr_i & ~in_window & ~bad_key;
	assign serviced = cause_wr_i & st_reg.armed
		& (cause_wdata_i == `WDOG_KEY_SECOND) & ~early;
	assign timeout = enable_i & (st_reg.cnt >= 32'(TIMEOUT - 1)) & inc
		& ~halted;
	assign illegal_opcode_flag = opcode_fetch_i & ((opcode_i == `WDOG_ILLEGAL_OPCODE_FLAG_A)
		| (opcode_i == `WDOG_ILLEGAL_OPCODE_FLAG_B));

	// Next state; a reset event wins over everything else
	always_comb begin
		st_next = st_reg;
		case (st_reg.state)
			WDOG_RUN: begin
				st_next.rst = 1'b0;
				if (cause_wr_i) begin
					st_next.armed = cause_wdata_i == `WDOG_KEY_FIRST;
				end
				if (!enable_i || serviced) begin
					st_next.cnt = 32'h0000_0000;
				end else if (watchdog_clock_select_i && halted) begin
					st_next.cnt = 32'h0000_0000;
				end else if (inc && !halted) begin
					st_next.cnt = st_reg.cnt + 32'h0000_0001;
				end
				if (timeout || early || bad_key || illegal_opcode_flag || illegal_addr_i) begin
					st_next.state = WDOG_RESET;
					st_next.rst = 1'b1;
					st_next.rst_cnt = 8'h00;
					st_next.cnt = 32'h0000_0000;
					st_next.armed = 1'b0;
					// Flags describe only the latest cause
					st_next.cop_flag = timeout | early | bad_key;
					st_next.illegal_opcode_flag_flag = illegal_opcode_flag;
					st_next.ilad_flag = illegal_addr_i;
				end
			end
			WDOG_RESET: begin
				st_next.rst = 1'b1;
				st_next.cnt = 32'h0000_0000;
				if (st_reg.rst_cnt >= 8'(RST_LEN - 1)) begin
					st_next.state = WDOG_RUN;
					st_next.rst = 1'b0;
				end else begin
					st_next.rst_cnt = st_reg.rst_cnt + 8'h01;
				end
			end
			default: begin
				st_next.state = WDOG_RUN;
				st_next.rst = 1'b0;
			end
		endcase
	end

	// State register; cause flags clear on nrst_i or when a later reset event has another cause
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign sys_reset_o = st_reg.rst;
	assign watchdog_cause_flag_o = st_reg.cop_flag;
	assign illegal_opcode_flag_o = st_reg.illegal_opcode_flag_flag;
	assign illegal_addr_flag_o = st_reg.ilad_flag;
	assign key_armed_o = st_reg.armed;
	assign count_o = st_reg.cnt;
endmodule : wdog_top
`default_nettype wire

// file: testbench/wdog_chk.sv
`default_nettype none
module wdog_chk #(
	parameter int unsigned TIMEOUT = 64
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic window_mode_select_i,
	input wire logic watchdog_clock_select_i,
	input wire logic stop_i,
	input wire logic debug_i,
	input wire logic cause_wr_i,
	input wire logic [7:0] cause_wdata_i,
	input wire logic opcode_fetch_i,
	input wire logic [7:0] opcode_i,
	input wire logic illegal_addr_i,
	input wire logic sys_reset_o,
	input wire logic watchdog_cause_flag_o,
	input wire logic illegal_opcode_flag_o,
	input wire logic key_armed_o,
	input wire logic [31:0] count_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	// Start of the service window, three quarters in
	localparam int unsigned WIN = TIMEOUT / 4 * 3;
	// Inputs are ignored while the reset pulse stands
	wire ok = !sys_reset_o;
	wire key = cause_wdata_i == 8'h55 || cause_wdata_i == 8'hAA;
	wire win = window_mode_select_i && !watchdog_clock_select_i;
	wire hold = stop_i || debug_i;
	property p_bad;
		ok && cause_wr_i && !key |=> sys_reset_o && watchdog_cause_flag_o;
	endproperty
	a_bad: assert property (p_bad) else $error("bad key kept running");
	property p_illegal_opcode_flag;
		ok && opcode_fetch_i && (opcode_i == 8'hAC || opcode_i == 8'h8D)
			|=> sys_reset_o && illegal_opcode_flag_o;
	endproperty
	a_illegal_opcode_flag: assert property (p_illegal_opcode_flag) else $error("bad opcode missed");
	property p_addr;
		ok && illegal_addr_i |=> $rose(sys_reset_o);
	endproperty
	a_addr: assert property (p_addr) else $error("bad address missed");
	property p_tmo;
		ok && !watchdog_clock_select_i && !hold && !cause_wr_i &&
			count_o == TIMEOUT - 1 |=> sys_reset_o && watchdog_cause_flag_o;
	endproperty
	a_tmo: assert property (p_tmo) else $error("timeout missed");
	property p_svc;
		ok && cause_wr_i && cause_wdata_i == 8'hAA && key_armed_o &&
			(!win || count_o >= WIN) |=> count_o == 0;
	endproperty
	a_svc: assert property (p_svc) else $error("service ignored");
	property p_early;
		ok && win && cause_wr_i && key && count_o < WIN |=> sys_reset_o;
	endproperty
	a_early: assert property (p_early) else $error("early write kept");
	property p_hold;
		ok && !watchdog_clock_select_i && hold && !cause_wr_i
			|=> $stable(count_o);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved in hold");
	property p_lpo;
		ok && watchdog_clock_select_i && hold |=> count_o == 0;
	endproperty
	a_lpo: assert property (p_lpo) else $error("count kept in hold");
	// Main paths reached
	c_tmo: cover property (sys_reset_o && watchdog_cause_flag_o);
	c_svc: cover property (cause_wr_i && key_armed_o && win);
	c_illegal_opcode_flag: cover property (sys_reset_o && illegal_opcode_flag_o);
endmodule : wdog_chk
bind wdog_top wdog_chk #(.TIMEOUT(TIMEOUT)) u_chk (.*);
`default_nettype wire

// file: testbench/tb_windowed_watchdog.sv
`default_nettype none
module tb_windowed_watchdog;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 0, nrst_i = 0, wm = 0, cs = 0, st = 0, db = 0;
	logic wr = 0, fe = 0, ia = 0;
	logic [7:0] wd = '0;
	logic sr, wf, of, af, ka;
	logic [31:0] cnt;
	int miscompares = 0, tests_run = 0, n;
	always #10 mclk_i = ~mclk_i;
	// Short counts keep the run small
	wdog_top #(.TIMEOUT(64), .LPO_DIV(4), .RST_LEN(4)) u_dut (.mclk_i,
		.nrst_i, .enable_i(1'h1), .window_mode_select_i(wm),
		.watchdog_clock_select_i(cs), .stop_i(st), .debug_i(db),
		.cause_wr_i(wr), .cause_wdata_i(wd), .opcode_fetch_i(fe),
		.opcode_i(wd), .illegal_addr_i(ia), .sys_reset_o(sr),
		.watchdog_cause_flag_o(wf), .illegal_opcode_flag_o(of),
		.illegal_addr_flag_o(af), .key_armed_o(ka), .count_o(cnt));
	task chk(input string s, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s exp %0h got %0h", s, e, g);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude
	// One-cycle strobe: k picks write, fetch or bad address
	task go(input logic [2:0] k, input logic [7:0] d);
		@(posedge mclk_i);
		{wr, fe, ia, wd} <= {k, d};
		@(posedge mclk_i);
		{wr, fe, ia} <= '0;
		#1;
	endtask : go
	// Bounded wait for the reset pulse; a hang ends the run
	task wt(input int lim);
		for (n = 0; !sr && n < lim; n++) @(posedge mclk_i) #1;
		chk("sys reset", 1, sr);
		if (!sr) conclude();
	endtask : wt
	// Let the reset pulse run out before the next test
	task done(input string s);
		repeat (8) @(posedge mclk_i);
		$display("%s done", s);
	endtask : done
	initial begin
		repeat (20) @(posedge mclk_i);
		nrst_i <= 1;
		go(3'h4, 8'h55);
		chk("key armed", 1, ka);
		go(3'h4, 8'hAA);
		chk("svc count", 1, cnt < 3);
		wt(90);
		chk("timeout at", 1, n > 55 && n < 70);
		chk("wd flag", 1, wf);
		done("timeout");
		go(3'h4, 8'h3C);
		wt(3);
		chk("wd flag", 1, wf);
		done("bad key");
		go(3'h2, 8'h9D);
		chk("legal op", 0, sr);
		for (int i = 0; i < 2; i++) begin
			go(3'h2, (i != 0) ? 8'h8D : 8'hAC);
			wt(3);
			chk("illegal_opcode_flag flag", 1, of);
			chk("wd flag", 0, wf);
			done("opcode");
		end
		go(3'h1, 8'h00);
		wt(3);
		chk("addr flag", 1, af);
		done("address");
		wm <= 1;
		go(3'h4, 8'h55);
		wt(3);
		done("early");
		for (n = 0; cnt < 50 && n < 99; n++) @(posedge mclk_i) #1;
		go(3'h4, 8'h55);
		go(3'h4, 8'hAA);
		chk("window svc", 1, cnt < 3 && !sr);
		cs <= 1;
		go(3'h4, 8'h55);
		go(3'h4, 8'hAA);
		chk("lpo window", 0, sr);
		repeat (12) @(posedge mclk_i);
		st <= 1;
		repeat (2) @(posedge mclk_i) #1;
		chk("lpo hold", 0, cnt);
		@(posedge mclk_i);
		{st, cs, wm} <= '0;
		repeat (10) @(posedge mclk_i);
		db <= 1;
		@(posedge mclk_i) #1;
		n = cnt;
		repeat (5) @(posedge mclk_i) #1;
		chk("bus hold", n, cnt);
		done("hold");
		conclude();
	end
endmodule : tb_windowed_watchdog
`default_nettype wire
